// [mif_defines.svh]
// Constants of the interrupt enable, priority and flag block.
// Assumes it is included by bare name by both ends and by the package users.
//
// Overview of operation
// - Extended enable gates eight extended sources
// - One priority bit per source, one means high
// - Basic priority holds seven standard source bits
// - Extended priority mirrors extended enable layout
// - Peripheral flags two to eight ignore writes
// - Two-wire flag set by hardware, software clears
// - Peripheral flag is OR of its sources
// - Timer 2 and watchdog flags cleared inside peripherals
// - Timer overflow flags clear on handler entry
// - Timer run bits are writable enables
// - Pin summary flags follow group flags, read-only
// - Per-pin enables gate group requests
// - Group zero flag set on edge, software clears
// - Group one flag set on edge, software clears
// - Edge polarity selected per pin from outside
// - Per-pin edge latches ORed into group request
// - Software clears pin flag before summary flag; here summary flags are read-only and drop with their pin flags
// - Remaining enabled pin flags keep request asserted
// - Global and individual enable both needed
// - Requests sampled each clock, highest one vectored
// - High level first, natural order within level
// - Debug above breakpoint above all peripherals
`ifndef MIF_DEFINES_SVH
`define MIF_DEFINES_SVH
// Special register addresses.
`define MIF_ADR_TIMER_CTL 8'h88
`define MIF_ADR_EXT_FLAGS 8'h91
`define MIF_ADR_P0EN 8'h96
`define MIF_ADR_P0FG 8'h97
`define MIF_ADR_BEN 8'ha8
`define MIF_ADR_P1EN 8'hae
`define MIF_ADR_P1FG 8'haf
`define MIF_ADR_BPRI 8'hb8
`define MIF_ADR_XEN 8'he8
`define MIF_ADR_XPRI 8'hf8
// Reset value shared by every register.
`define MIF_RST_VAL 8'h00
// Timer control bit positions.
`define MIF_TC_T1_OVF 7
`define MIF_TC_T1_RUN 6
`define MIF_TC_T0_OVF 5
`define MIF_TC_T0_RUN 4
`define MIF_TC_P1F 3
`define MIF_TC_P0F 1
// Vector addresses.
`define MIF_VEC_BASE 8'h03
`define MIF_VEC_STEP 8'h08
`define MIF_VEC_T0_OVF 8'h0b
`define MIF_VEC_T1_OVF 8'h1b
`define MIF_VEC_BREAK 8'h7b
`define MIF_VEC_DEBUG 8'h83
// Controller register byte offsets on the APB side.
`define MIF_APB_CMD 12'h000
`define MIF_APB_STAT 12'h004
`define MIF_APB_IRQ 12'h008
`define MIF_APB_ACK 12'h00c
`endif

// [mif_pkg.sv]
// Types shared by both ends of the interrupt block.
// Assumes no other package; users write mif_pkg::name.
package mif_pkg;
  // One special-register byte.
  typedef logic [7:0] mif_byte_t;
  // Number of vectored peripheral sources.
  localparam int NSRC = 15;
  // Pending, enable or priority vector over the peripheral sources.
  typedef logic [NSRC-1:0] mif_src_t;
endpackage

// [mif_if.sv]
// Special register port and vector handshake between core and interrupt logic.
// Assumes one shared clock; the testbench instantiates and connects it.
`timescale 1ns/1ps
interface mif_if (
  input wire logic i_clk
);
  // Register access from the core.
  logic [7:0] sfr_addr;
  logic [7:0] sfr_wdata;
  logic sfr_wr;
  logic sfr_rd;
  logic [7:0] sfr_rdata;
  // Vector request and handler entry.
  logic irq_req;
  logic [7:0] irq_vec;
  logic irq_ack;
  logic [7:0] ack_vec;
  // The interrupt block end.
  modport dev (input i_clk, input sfr_addr, input sfr_wdata, input sfr_wr, input sfr_rd,
               output sfr_rdata, output irq_req, output irq_vec, input irq_ack,
               input ack_vec);
  // The core end.
  modport core (input i_clk, output sfr_addr, output sfr_wdata, output sfr_wr,
                output sfr_rd, input sfr_rdata, input irq_req, input irq_vec,
                output irq_ack, output ack_vec);
endinterface

// [mif_core_end.sv]
// Core end: takes orders over APB and drives the special register port.
// Assumes APB on the same clock and a device that answers reads one cycle later.
`timescale 1ns/1ps
`include "mif_defines.svh"
module mif_core_end (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst,
  // APB slave.
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Link to the interrupt block.
  mif_if.core link
);
  // Access phase of an APB transfer.
  logic acc;
  // Address is one of ours.
  logic hit;
  // Register access driven on the link.
  logic [7:0] addr_reg;
  logic [7:0] wdata_reg;
  logic wr_reg;
  logic rd_reg;
  // Read answer captured from the link.
  logic [7:0] rdata_reg;
  // A read answer arrives in the next cycle.
  logic rd_wait_reg;
  // Handler entry pulse and its vector.
  logic ack_reg;
  logic [7:0] ackv_reg;
  // Read data register.
  logic [31:0] prdata_reg;

  assign acc = i_psel && i_penable;
  assign hit = (i_paddr == `MIF_APB_CMD) || (i_paddr == `MIF_APB_STAT) ||
               (i_paddr == `MIF_APB_IRQ) || (i_paddr == `MIF_APB_ACK);
  // Every access completes in its first access cycle.
  assign o_pready = 1'b1;
  assign o_pslverr = acc && !hit;
  assign o_prdata = prdata_reg;
  assign link.sfr_addr = addr_reg;
  assign link.sfr_wdata = wdata_reg;
  assign link.sfr_wr = wr_reg;
  assign link.sfr_rd = rd_reg;
  assign link.irq_ack = ack_reg;
  assign link.ack_vec = ackv_reg;

  // Command word: bits 7:0 address, 15:8 write data, 16 write, 17 read.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      addr_reg <= `MIF_RST_VAL;
      wdata_reg <= `MIF_RST_VAL;
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
    end else if (acc && i_pwrite && i_paddr == `MIF_APB_CMD) begin
      addr_reg <= i_pwdata[7:0];
      wdata_reg <= i_pwdata[15:8];
      wr_reg <= i_pwdata[16];
      rd_reg <= i_pwdata[17] && !i_pwdata[16];
    end else begin
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
    end
  end

  // Capture the read answer one cycle after the read strobe.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rd_wait_reg <= 1'b0;
      rdata_reg <= `MIF_RST_VAL;
    end else begin
      rd_wait_reg <= rd_reg;
      if (rd_wait_reg) begin
        rdata_reg <= link.sfr_rdata;
      end
    end
  end

  // A write to the acknowledge word enters the handler of the vector shown now.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ack_reg <= 1'b0;
      ackv_reg <= `MIF_RST_VAL;
    end else begin
      ack_reg <= acc && i_pwrite && i_paddr == `MIF_APB_ACK && link.irq_req;
      ackv_reg <= link.irq_vec;
    end
  end

  // Read mux, registered at the edge that ends the setup phase.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      prdata_reg <= 32'h0;
    end else if (i_psel && !i_penable && !i_pwrite) begin
      unique case (i_paddr)
        `MIF_APB_CMD: prdata_reg <= {14'h0, rd_reg, wr_reg, wdata_reg, addr_reg};
        `MIF_APB_STAT: prdata_reg <= {23'h0, rd_reg || rd_wait_reg, rdata_reg};
        `MIF_APB_IRQ: prdata_reg <= {23'h0, link.irq_req, link.irq_vec};
        default: prdata_reg <= 32'h0;
      endcase
    end
  end
endmodule

// [mif_irq_end.sv]
// Interrupt enable, priority and flag logic with pin expansion.
// Assumes a core that accesses registers on the link and acknowledges vectors.
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
`include "mif_defines.svh"
module mif_irq_end #(
  parameter int G0_PINS = 4,
  parameter int G1_PINS = 6,
  parameter int SUBSRC = 4
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst,
  // Link to the core.
  mif_if.dev link,
  // Expanded pins and their edge selection, one means rising.
  input wire logic [G0_PINS-1:0] i_pin_group0,
  input wire logic [G1_PINS-1:0] i_pin_group1,
  input wire logic [G0_PINS-1:0] i_pin_edge_config0,
  input wire logic [G1_PINS-1:0] i_pin_edge_config1,
  // Internal peripheral events and flags.
  input wire logic i_timer0_ovf,
  input wire logic i_timer1_ovf,
  input wire logic i_timer2_flag,
  input wire logic i_watchdog_flag,
  input wire logic i_uart0_flag,
  input wire logic i_uart2_flag,
  input wire logic i_twowire_master_event,
  // Source flags of external peripherals, sources 2 to 8.
  input wire logic [6:0][SUBSRC-1:0] i_ext_src_flags,
  // Debug and breakpoint requests.
  input wire logic i_debug_request_irq,
  input wire logic i_breakpoint_irq,
  // Timer run controls.
  output logic o_timer0_run,
  output logic o_timer1_run
);
  // Software-written registers.
  logic [7:0] basic_enable_reg;
  logic [7:0] basic_priority_reg;
  logic [7:0] extended_enable_reg;
  logic [7:0] extended_priority_reg;
  logic [G0_PINS-1:0] pin_group0_enable_reg;
  logic [G1_PINS-1:0] pin_group1_enable_reg;
  logic timer0_run_reg;
  logic timer1_run_reg;
  // Hardware-set flags.
  logic [G0_PINS-1:0] pin_group0_flags_reg;
  logic [G1_PINS-1:0] pin_group1_flags_reg;
  logic timer0_overflow_flag_reg;
  logic timer1_overflow_flag_reg;
  logic twowire_master_flag_reg;
  // Pin synchronisers and previous level.
  logic [G0_PINS-1:0] p0_s1_reg, p0_s2_reg, p0_old_reg;
  logic [G1_PINS-1:0] p1_s1_reg, p1_s2_reg, p1_old_reg;
  // Qualified edges per pin.
  logic [G0_PINS-1:0] p0_edge;
  logic [G1_PINS-1:0] p1_edge;
  // Register write strobes.
  logic wr_ext_flags, wr_p0fg, wr_p1fg;
  // Peripheral flag summaries, index 0 is source 2.
  logic [6:0] ext_flag;
  // Group summary flags.
  logic pin_group0_summary_flag;
  logic pin_group1_summary_flag;
  // Group requests, gated by the per-pin enables.
  logic pin_group0_request;
  logic pin_group1_request;
  // Winners of the high and the low level, found flag on top.
  logic [4:0] hi;
  logic [4:0] lo;
  // Pending, enable and priority vectors in natural order.
  mif_pkg::mif_src_t pend, en, prio;
  // Registered outputs toward the core.
  logic req_reg;
  logic [7:0] vec_reg;
  logic [7:0] rdata_reg;

  // Vector of a natural position, counting from the first vector.
  function automatic logic [7:0] vec_of(input logic [3:0] idx);
    vec_of = `MIF_VEC_BASE + {idx[3:0], 3'b000};
  endfunction

  // Index of the first set bit in natural order, with a found flag.
  function automatic logic [4:0] first_set(input mif_pkg::mif_src_t v);
    first_set = 5'h00;
    for (int k = mif_pkg::NSRC - 1; k >= 0; k--) begin
      if (v[k]) begin
        first_set = {1'b1, 4'(k)};
      end
    end
  endfunction

  assign wr_ext_flags = link.sfr_wr && link.sfr_addr == `MIF_ADR_EXT_FLAGS;
  assign wr_p0fg = link.sfr_wr && link.sfr_addr == `MIF_ADR_P0FG;
  assign wr_p1fg = link.sfr_wr && link.sfr_addr == `MIF_ADR_P1FG;

  // Each external peripheral flag is the OR of its own source flags.
  generate
    for (genvar g = 0; g < 7; g++) begin : g_ext
      assign ext_flag[g] = |i_ext_src_flags[g];
    end
  endgenerate

  // Summary bits show every latched pin flag, enabled or not.
  assign pin_group0_summary_flag = |pin_group0_flags_reg;
  assign pin_group1_summary_flag = |pin_group1_flags_reg;
  // Requests take enabled flags only, so leftover flags re-request.
  assign pin_group0_request = |(pin_group0_flags_reg &
                                pin_group0_enable_reg);
  assign pin_group1_request = |(pin_group1_flags_reg &
                                pin_group1_enable_reg);

  // Sources in natural order; timer 2 and watchdog come straight from peripherals.
  assign pend = {ext_flag[6], ext_flag[5], ext_flag[4], i_watchdog_flag, ext_flag[2],
                 ext_flag[1], ext_flag[0], twowire_master_flag_reg, i_uart2_flag,
                 i_timer2_flag, i_uart0_flag, timer1_overflow_flag_reg,
                 pin_group1_request, timer0_overflow_flag_reg,
                 pin_group0_request};
  // Both enable layouts already line up with natural order.
  assign en = {extended_enable_reg, basic_enable_reg[6:0]} &
              {mif_pkg::NSRC{basic_enable_reg[7]}};
  assign prio = {extended_priority_reg, basic_priority_reg[6:0]};
  // First pending enabled source in each level, in natural order.
  assign hi = first_set(pend & en & prio);
  assign lo = first_set(pend & en & ~prio);

  // Edge qualification on synchronised levels, polarity chosen per pin.
  assign p0_edge = (p0_s2_reg & ~p0_old_reg & i_pin_edge_config0) |
                   (~p0_s2_reg & p0_old_reg & ~i_pin_edge_config0);
  assign p1_edge = (p1_s2_reg & ~p1_old_reg & i_pin_edge_config1) |
                   (~p1_s2_reg & p1_old_reg & ~i_pin_edge_config1);

  // Two-flop pin synchronisers plus a previous-level stage.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      p0_s1_reg <= '0;
      p0_s2_reg <= '0;
      p0_old_reg <= '0;
      p1_s1_reg <= '0;
      p1_s2_reg <= '0;
      p1_old_reg <= '0;
    end else begin
      p0_s1_reg <= i_pin_group0;
      p0_s2_reg <= p0_s1_reg;
      p0_old_reg <= p0_s2_reg;
      p1_s1_reg <= i_pin_group1;
      p1_s2_reg <= p1_s1_reg;
      p1_old_reg <= p1_s2_reg;
    end
  end

  // Pin flags: writing zero clears a bit, a new edge in the same cycle wins.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pin_group0_flags_reg <= '0;
      pin_group1_flags_reg <= '0;
    end else begin
      pin_group0_flags_reg <= (wr_p0fg ? pin_group0_flags_reg & link.sfr_wdata[G0_PINS-1:0]
                               : pin_group0_flags_reg) | p0_edge;
      pin_group1_flags_reg <= (wr_p1fg ? pin_group1_flags_reg & link.sfr_wdata[G1_PINS-1:0]
                               : pin_group1_flags_reg) | p1_edge;
    end
  end

  // Timer overflow flags clear on entry to their own handler; a new overflow wins.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      timer0_overflow_flag_reg <= 1'b0;
      timer1_overflow_flag_reg <= 1'b0;
    end else begin
      timer0_overflow_flag_reg <= i_timer0_ovf || (timer0_overflow_flag_reg &&
                                  !(link.irq_ack && link.ack_vec == `MIF_VEC_T0_OVF));
      timer1_overflow_flag_reg <= i_timer1_ovf || (timer1_overflow_flag_reg &&
                                  !(link.irq_ack && link.ack_vec == `MIF_VEC_T1_OVF));
    end
  end

  // Two-wire master flag: only software clears it, the event wins.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      twowire_master_flag_reg <= 1'b0;
    end else begin
      twowire_master_flag_reg <= i_twowire_master_event || (twowire_master_flag_reg &&
                                 !(wr_ext_flags && !link.sfr_wdata[0]));
    end
  end

  // Plain read-write control registers.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      basic_enable_reg <= `MIF_RST_VAL;
      basic_priority_reg <= `MIF_RST_VAL;
      extended_enable_reg <= `MIF_RST_VAL;
      extended_priority_reg <= `MIF_RST_VAL;
      pin_group0_enable_reg <= '0;
      pin_group1_enable_reg <= '0;
      timer0_run_reg <= 1'b0;
      timer1_run_reg <= 1'b0;
    end else if (link.sfr_wr) begin
      unique case (link.sfr_addr)
        `MIF_ADR_BEN: basic_enable_reg <= link.sfr_wdata;
        `MIF_ADR_BPRI: basic_priority_reg <= {1'b0, link.sfr_wdata[6:0]};
        `MIF_ADR_XEN: extended_enable_reg <= link.sfr_wdata;
        `MIF_ADR_XPRI: extended_priority_reg <= link.sfr_wdata;
        `MIF_ADR_P0EN: pin_group0_enable_reg <= link.sfr_wdata[G0_PINS-1:0];
        `MIF_ADR_P1EN: pin_group1_enable_reg <= link.sfr_wdata[G1_PINS-1:0];
        `MIF_ADR_TIMER_CTL: begin
          timer1_run_reg <= link.sfr_wdata[`MIF_TC_T1_RUN];
          timer0_run_reg <= link.sfr_wdata[`MIF_TC_T0_RUN];
        end
        default: begin
        end
      endcase
    end
  end

  // Read answer one cycle after the strobe; unused bits read zero.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rdata_reg <= `MIF_RST_VAL;
    end else if (link.sfr_rd) begin
      unique case (link.sfr_addr)
        `MIF_ADR_TIMER_CTL: rdata_reg <= {timer1_overflow_flag_reg, timer1_run_reg,
                                     timer0_overflow_flag_reg, timer0_run_reg,
                                     pin_group1_summary_flag, 1'b0,
                                     pin_group0_summary_flag, 1'b0};
        `MIF_ADR_EXT_FLAGS: rdata_reg <= {ext_flag[6:4], 1'b0, ext_flag[2:0],
                                     twowire_master_flag_reg};
        `MIF_ADR_BEN: rdata_reg <= basic_enable_reg;
        `MIF_ADR_BPRI: rdata_reg <= basic_priority_reg;
        `MIF_ADR_XEN: rdata_reg <= extended_enable_reg;
        `MIF_ADR_XPRI: rdata_reg <= extended_priority_reg;
        `MIF_ADR_P0EN: rdata_reg <= 8'(pin_group0_enable_reg);
        `MIF_ADR_P0FG: rdata_reg <= 8'(pin_group0_flags_reg);
        `MIF_ADR_P1EN: rdata_reg <= 8'(pin_group1_enable_reg);
        `MIF_ADR_P1FG: rdata_reg <= 8'(pin_group1_flags_reg);
        default: rdata_reg <= `MIF_RST_VAL;
      endcase
    end
  end

  // Vector choice sampled each edge: debug, breakpoint, high level, low level.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      req_reg <= 1'b0;
      vec_reg <= `MIF_RST_VAL;
    end else begin
      req_reg <= i_debug_request_irq || i_breakpoint_irq || hi[4] || lo[4];
      if (i_debug_request_irq) begin
        vec_reg <= `MIF_VEC_DEBUG;
      end else if (i_breakpoint_irq) begin
        vec_reg <= `MIF_VEC_BREAK;
      end else if (hi[4]) begin
        vec_reg <= vec_of(hi[3:0]);
      end else if (lo[4]) begin
        vec_reg <= vec_of(lo[3:0]);
      end else begin
        vec_reg <= `MIF_RST_VAL;
      end
    end
  end

  assign link.sfr_rdata = rdata_reg;
  assign link.irq_req = req_reg;
  assign link.irq_vec = vec_reg;
  assign o_timer0_run = timer0_run_reg;
  assign o_timer1_run = timer1_run_reg;
endmodule

// [mif_props.sv]
// Checker of the link between the core end and the interrupt end.
// Assumes one clock and the synchronous active-high reset of the bench.
`timescale 1ns/1ps
module mif_props (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst,
  // Link signals.
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic irq_req,
  input wire logic [7:0] irq_vec,
  input wire logic irq_ack,
  input wire logic [7:0] ack_vec
);
  // All checks share the one clock and the reset.
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  // A request is pending exactly when a vector is offered.
  a_req_vec: assert property (irq_req == (irq_vec != 8'h00))
    else $error("request and vector disagree");
  // Offered vectors lie on the eight-byte grid, debug at the top.
  a_vec_grid: assert property (irq_req |-> irq_vec[2:0] == 3'h3 && irq_vec <= 8'h83)
    else $error("vector off grid");
  // Handler entry is signalled only while a request was pending.
  a_ack_req: assert property (irq_ack |-> $past(irq_req))
    else $error("entry without request");
  // Handler entry is a single pulse carrying a legal vector.
  a_ack_pulse: assert property (irq_ack |-> ack_vec[2:0] == 3'h3 ##1 !irq_ack)
    else $error("entry pulse malformed");
  // Timer overflow flags drop on entry, so their vector is gone two edges later.
  a_tf_clear: assert property (irq_ack && (ack_vec == 8'h0b || ack_vec == 8'h1b)
    |-> ##2 irq_vec != $past(ack_vec, 2))
    else $error("timer flag not cleared on entry");
  // Never a read and a write in one cycle.
  a_strobe_one: assert property (!(sfr_wr && sfr_rd))
    else $error("read and write together");
  // Each register access strobe lasts one cycle.
  a_strobe_pulse: assert property ((sfr_wr || sfr_rd) |=> !(sfr_wr || sfr_rd))
    else $error("strobe longer than one cycle");
  // Read data holds between reads.
  a_rdata_hold: assert property (!$past(sfr_rd) |-> $stable(sfr_rdata))
    else $error("read data moved without a read");
  // Main scenarios reached.
  c_entry: cover property (irq_ack);
  c_debug: cover property (irq_req && irq_vec == 8'h83);
  c_read: cover property (sfr_rd ##1 sfr_rdata != 8'h00);
endmodule

// [mif_bench.sv]
// Self-checking bench: APB drives the core end, which talks to the interrupt end.
// Assumes both ends and the link interface are compiled before it.
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module mif_bench;
  // Clock, reset and APB.
  logic i_clk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  // Pins, edge selection and peripheral inputs.
  logic [3:0] p0, cfg0;
  logic [5:0] p1, cfg1;
  logic t0, t1, t2, wd, tw, u0, u2, dreq, brk, run0, run1;
  logic [6:0][3:0] ext;
  logic [7:0] q;
  int fails, cmp_count;
  mif_if link (.i_clk(i_clk));
  mif_core_end i_mif_core_end (.i_clk(i_clk), .i_rst(rst), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .link(link));
  mif_irq_end i_mif_irq_end (.i_clk(i_clk), .i_rst(rst), .link(link), .i_pin_group0(p0),
    .i_pin_group1(p1), .i_pin_edge_config0(cfg0), .i_pin_edge_config1(cfg1),
    .i_timer0_ovf(t0), .i_timer1_ovf(t1), .i_timer2_flag(t2), .i_watchdog_flag(wd),
    .i_uart0_flag(u0), .i_uart2_flag(u2), .i_twowire_master_event(tw),
    .i_ext_src_flags(ext), .i_debug_request_irq(dreq), .i_breakpoint_irq(brk),
    .o_timer0_run(run0), .o_timer1_run(run1));
  mif_props i_mif_props (.i_clk(i_clk), .i_rst(rst), .sfr_wr(link.sfr_wr),
    .sfr_rd(link.sfr_rd), .sfr_rdata(link.sfr_rdata), .irq_req(link.irq_req),
    .irq_vec(link.irq_vec), .irq_ack(link.irq_ack), .ack_vec(link.ack_vec));
  // Free-running clock of 100 ns.
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  // Prints the counts and the verdict, then stops.
  task finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // One APB transfer; data and error are taken at the edge with pready high.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    @(posedge i_clk);
    while (pready !== 1'b1) @(posedge i_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Register access through the command word, then poll until idle.
  task sfr(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    apb(1'b1, 12'h000, {14'h0, !w, w, d, a});
    do begin
      apb(1'b0, 12'h004, 32'h0);
      n++;
    end while (rd[8] !== 1'b0 && n < 20);
    if (rd[8] !== 1'b0) fails++;
    q = rd[7:0];
  endtask
  // Reads one register and compares it.
  task rg(input logic [7:0] a, input logic [7:0] e);
    sfr(1'b0, a, 8'h00);
    `CHK($sformatf("sfr %h", a), e, q)
  endtask
  // Lets causes settle, then compares the offered vector.
  task vec(input logic [7:0] e);
    repeat (8) @(posedge i_clk);
    `CHK("irq_vec", e, link.irq_vec)
  endtask
  // Reset values, masks of writable bits, refused accesses.
  task t_regs;
    logic [7:0] adr [9];
    logic [7:0] msk [9];
    adr = '{8'h88, 8'h91, 8'h96, 8'h97, 8'hae, 8'haf, 8'hb8, 8'he8, 8'hf8};
    msk = '{8'h50, 8'h00, 8'h0f, 8'h00, 8'h3f, 8'h00, 8'h7f, 8'hff, 8'hff};
    foreach (adr[i]) rg(adr[i], 8'h00);
    foreach (adr[i]) begin
      sfr(1'b1, adr[i], 8'hff);
      rg(adr[i], msk[i]);
    end
    `CHK("run", 2'b11, {run1, run0})
    foreach (adr[i]) sfr(1'b1, adr[i], 8'h00);
    `CHK("run", 2'b00, {run1, run0})
    apb(1'b0, 12'h010, 32'h0);
    `CHK("pslverr", 1'b1, err)
    `CHK("prdata", 32'h0, rd)
    rg(8'h80, 8'h00);
  endtask
  // Peripheral flag mirror, enables and priority order.
  task t_ext;
    for (int i = 0; i < 7; i++) begin
      @(posedge i_clk);
      ext <= 28'h1 << (4 * i);
      rg(8'h91, i == 3 ? 8'h00 : 8'h01 << (i + 1));
    end
    ext <= {4'h5, 24'h0};
    sfr(1'b1, 8'h91, 8'h00);
    rg(8'h91, 8'h80);
    ext <= {4'h4, 24'h0};
    rg(8'h91, 8'h80);
    sfr(1'b1, 8'he8, 8'h80);
    vec(8'h00);
    sfr(1'b1, 8'ha8, 8'h80);
    vec(8'h73);
    u0 <= 1'b1;
    sfr(1'b1, 8'ha8, 8'h90);
    vec(8'h23);
    sfr(1'b1, 8'hf8, 8'h80);
    vec(8'h73);
    u2 <= 1'b1;
    sfr(1'b1, 8'ha8, 8'hd0);
    sfr(1'b1, 8'hb8, 8'h40);
    sfr(1'b1, 8'hf8, 8'h00);
    vec(8'h33);
    brk <= 1'b1;
    vec(8'h7b);
    dreq <= 1'b1;
    sfr(1'b1, 8'ha8, 8'h00);
    vec(8'h83);
    dreq <= 1'b0; brk <= 1'b0; u0 <= 1'b0; u2 <= 1'b0; ext <= '0;
    sfr(1'b1, 8'hb8, 8'h00);
    sfr(1'b1, 8'he8, 8'h00);
    vec(8'h00);
  endtask
  // Timer overflow flags set by a pulse and cleared on handler entry.
  task t_tmr;
    for (int i = 0; i < 2; i++) begin
      sfr(1'b1, 8'ha8, i ? 8'h88 : 8'h82);
      @(posedge i_clk);
      if (i) t1 <= 1'b1; else t0 <= 1'b1;
      @(posedge i_clk);
      t0 <= 1'b0; t1 <= 1'b0;
      rg(8'h88, i ? 8'h80 : 8'h20);
      vec(i ? 8'h1b : 8'h0b);
      apb(1'b1, 12'h00c, 32'h0);
      rg(8'h88, 8'h00);
      vec(8'h00);
    end
    // Timer 2 and watchdog flags live in the peripheral and drop only there.
    sfr(1'b1, 8'ha8, 8'ha0);
    t2 <= 1'b1;
    vec(8'h2b);
    t2 <= 1'b0;
    vec(8'h00);
    sfr(1'b1, 8'ha8, 8'h80);
    sfr(1'b1, 8'he8, 8'h10);
    wd <= 1'b1;
    vec(8'h5b);
    wd <= 1'b0;
    vec(8'h00);
  endtask
  // Two-wire master flag is sticky until written clear.
  task t_tw;
    sfr(1'b1, 8'ha8, 8'h80);
    sfr(1'b1, 8'he8, 8'h01);
    @(posedge i_clk);
    tw <= 1'b1;
    @(posedge i_clk);
    tw <= 1'b0;
    vec(8'h3b);
    repeat (20) @(posedge i_clk);
    sfr(1'b1, 8'h91, 8'h01);
    rg(8'h91, 8'h01);
    sfr(1'b1, 8'h91, 8'h00);
    rg(8'h91, 8'h00);
    vec(8'h00);
  endtask
  // Expanded pin flags, enables, summaries and re-entry.
  task t_pin;
    sfr(1'b1, 8'he8, 8'h00);
    sfr(1'b1, 8'ha8, 8'h85);
    sfr(1'b1, 8'h96, 8'h01);
    cfg0 <= 4'h1;
    p0 <= 4'h3;
    rg(8'h97, 8'h01);
    rg(8'h88, 8'h02);
    vec(8'h03);
    sfr(1'b1, 8'h88, 8'h00);
    rg(8'h88, 8'h02);
    sfr(1'b1, 8'h97, 8'h00);
    rg(8'h97, 8'h00);
    vec(8'h00);
    p0 <= 4'h1;
    rg(8'h97, 8'h02);
    rg(8'h88, 8'h02);
    vec(8'h00);
    sfr(1'b1, 8'h97, 8'h00);
    sfr(1'b1, 8'hae, 8'h21);
    p1 <= 6'h1e;
    rg(8'haf, 8'h21);
    vec(8'h13);
    sfr(1'b1, 8'haf, 8'h01);
    vec(8'h13);
    rg(8'h88, 8'h08);
    sfr(1'b1, 8'haf, 8'h00);
    sfr(1'b1, 8'h88, 8'h00);
    vec(8'h00);
    p1 <= 6'h3f;
    rg(8'haf, 8'h00);
  endtask
  // Main sequence.
  initial begin
    rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
    p0 = '0; p1 = 6'h3f; cfg0 = '0; cfg1 = '0; ext = '0; fails = 0; cmp_count = 0;
    t0 = 1'b0; t1 = 1'b0; t2 = 1'b0; wd = 1'b0; tw = 1'b0; u0 = 1'b0; u2 = 1'b0;
    dreq = 1'b0; brk = 1'b0;
    repeat (2) @(posedge i_clk);
    rst <= 1'b0;
    t_regs;
    t_ext;
    t_tmr;
    t_tw;
    t_pin;
    finish_test;
  end
  // Cuts a hang short.
  initial begin
    repeat (40000) @(posedge i_clk);
    fails++;
    finish_test;
  end
endmodule
